// [rtl/etg_fifo.sv]
// small fifo with a registered read port between frame builder and stream
`timescale 1ns/1ns
`default_nettype none
module etg_fifo #(
    parameter int WIDTH = 73,
    parameter int DEPTH = 8
) (
    input  wire logic             ref_clk,
    input  wire logic             rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    wr_d;
    logic [AW-1:0]    rd_q;
    logic [AW-1:0]    rd_d;
    logic [AW:0]      cnt_q;
    logic [AW:0]      cnt_d;
    logic             out_valid_q;
    logic             out_valid_d;
    logic [WIDTH-1:0] out_data_q;
    logic [WIDTH-1:0] out_data_d;
    logic             push;
    logic             load;

    function automatic logic [AW-1:0] ptr_next(input logic [AW-1:0] p);
        ptr_next = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
    endfunction : ptr_next

    assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = out_valid_q;
    assign out_data  = out_data_q;

    always_comb begin
        push        = in_valid && in_ready;
        // the output register refills whenever entries are stored and it is empty or being taken
        load        = (cnt_q != '0) && (!out_valid_q || out_ready);
        wr_d        = push ? ptr_next(wr_q) : wr_q;
        rd_d        = load ? ptr_next(rd_q) : rd_q;
        cnt_d       = cnt_q;
        if (push && !load) begin
            cnt_d = (AW+1)'(cnt_q + 1'b1);
        end else if (load && !push) begin
            cnt_d = (AW+1)'(cnt_q - 1'b1);
        end
        out_data_d  = load ? mem_q[rd_q] : out_data_q;
        out_valid_d = load ? 1'b1 : (out_ready ? 1'b0 : out_valid_q);
    end

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wr_q        <= '0;
            rd_q        <= '0;
            cnt_q       <= '0;
            out_valid_q <= 1'b0;
            out_data_q  <= '0;
        end else begin
            wr_q        <= wr_d;
            rd_q        <= rd_d;
            cnt_q       <= cnt_d;
            out_valid_q <= out_valid_d;
            out_data_q  <= out_data_d;
        end
    end

    chk_fifo_count : assert property (@(posedge ref_clk) disable iff (rst)
        cnt_q <= (AW+1)'(DEPTH))
        else $error("fifo count above depth");

endmodule : etg_fifo
`default_nettype wire

// [rtl/etg_frame_gen.sv]
// test frame generator driving a 64-bit stream transmit port
//
// Functional notes
// - payload size clamped to 46..1500 bytes
// - addresses fixed by 48-bit parameters
// - length field carries selected payload size
// - frame is 14 header bytes plus payload
// - sequence counter in frame, plus one per frame
// - fixed lane layout of first two beats
// - channel selects default address pair, swapped
// - one stream clock, synchronous reset
// - 64-bit data bus, eight bytes per beat
// - keep marks valid bytes of accepted beats
// - keep bit 0 is lowest data byte
// - keep all ones except last beat, packed low
// - last asserted only on final beat
// - valid means beat presented, held until taken
// - underrun sideband always low
// - transfer only when valid and ready high
// - enable makes this generator feed the stream
// - active only in internal generation mode; a frame already started still runs to its end after enable drops
`timescale 1ns/1ns
`default_nettype none
module etg_frame_gen #(
    parameter int                       CHANNEL                 = 0,
    parameter logic [etg_pkg::ADDR_W-1:0] local_source_addr_param =
        (CHANNEL == 0) ? etg_pkg::ADDR_CH0 : etg_pkg::ADDR_CH1,
    parameter logic [etg_pkg::ADDR_W-1:0] peer_dest_addr_param    =
        (CHANNEL == 0) ? etg_pkg::ADDR_CH1 : etg_pkg::ADDR_CH0,
    parameter int                       DEPTH                   = etg_pkg::FIFO_DEPTH
) (
    input  wire logic                         ref_clk,
    input  wire logic                         rst,
    input  wire logic                         enable_gen,
    input  wire logic [etg_pkg::LEN_W-1:0]    data_payload,
    input  wire logic                         tx_axis_tready,
    output logic      [etg_pkg::DATA_W-1:0]   tx_axis_tdata,
    output logic      [etg_pkg::KEEP_W-1:0]   tx_axis_tkeep,
    output logic                              tx_axis_tlast,
    output logic                              tx_axis_tvalid,
    output logic                              tx_axis_tuser
);
    import etg_pkg::*;

    etg_state_t        state_q;
    etg_state_t        state_d;
    logic [LEN_W-1:0]  len_q;
    logic [LEN_W-1:0]  len_d;
    logic [BEAT_W-1:0] last_beat_q;
    logic [BEAT_W-1:0] last_beat_d;
    logic [KEEP_W-1:0] keep_last_q;
    logic [KEEP_W-1:0] keep_last_d;
    logic [BEAT_W-1:0] beat_q;
    logic [BEAT_W-1:0] beat_d;
    logic [SEQ_W-1:0]  seq_q;
    logic [SEQ_W-1:0]  seq_d;
    logic              tuser_q;

    logic [LEN_W-1:0]  pay_sel;
    logic [LEN_W-1:0]  total_bytes;
    logic [LEN_W-1:0]  beat_total;
    logic              push;
    logic              is_last;
    logic              fifo_in_ready;
    logic [DATA_W-1:0] beat_data;
    logic [KEEP_W-1:0] beat_keep;
    logic [FIFO_W-1:0] fifo_out;

    // places a big-endian word so that its first byte travels in lane 0
    function automatic logic [DATA_W-1:0] to_lanes(input logic [DATA_W-1:0] be);
        logic [DATA_W-1:0] r;
        r = '0;
        for (int i = 0; i < KEEP_W; i++) begin
            r[8*i +: 8] = be[DATA_W-8-8*i +: 8];
        end
        to_lanes = r;
    endfunction : to_lanes

    // keep pattern for a final beat holding rem bytes, zero meaning eight
    function automatic logic [KEEP_W-1:0] keep_of(input logic [2:0] rem);
        keep_of = (rem == 3'h0) ? KEEP_ALL : KEEP_W'((KEEP_ONE << rem) - KEEP_ONE);
    endfunction : keep_of

    // frame builder
    always_comb begin
        if (data_payload < PAYLOAD_MIN) begin
            pay_sel = PAYLOAD_MIN;
        end else if (data_payload > PAYLOAD_MAX) begin
            pay_sel = PAYLOAD_MAX;
        end else begin
            pay_sel = data_payload;
        end
        total_bytes = LEN_W'(pay_sel + HDR_BYTES);
        beat_total  = LEN_W'((total_bytes + BEAT_ROUND) >> 3);
        state_d     = state_q;
        len_d       = len_q;
        last_beat_d = last_beat_q;
        keep_last_d = keep_last_q;
        beat_d      = beat_q;
        seq_d       = seq_q;
        push        = 1'b0;
        unique case (state_q)
            ST_IDLE: begin
                // new frames start only while this generator is selected
                if (enable_gen) begin
                    len_d       = pay_sel;
                    last_beat_d = BEAT_W'(beat_total - 1'b1);
                    keep_last_d = keep_of(total_bytes[2:0]);
                    beat_d      = BEAT_HDR0;
                    state_d     = ST_SEND;
                end
            end
            ST_SEND: begin
                // the frame runs to its end regardless of enable
                push = fifo_in_ready;
                if (push) begin
                    if (beat_q == last_beat_q) begin
                        state_d = ST_IDLE;
                        seq_d   = SEQ_W'(seq_q + SEQ_STEP);
                    end else begin
                        beat_d = BEAT_W'(beat_q + BEAT_STEP);
                    end
                end
            end
        endcase
    end

    // beat contents
    always_comb begin
        is_last = (beat_q == last_beat_q);
        if (beat_q == BEAT_HDR0) begin
            beat_data = to_lanes({peer_dest_addr_param,
                                  local_source_addr_param[47:32]});
        end else if (beat_q == BEAT_HDR1) begin
            beat_data = to_lanes({local_source_addr_param[31:0], len_q, seq_q});
        end else begin
            beat_data = to_lanes({4{seq_q}});
        end
        beat_keep = is_last ? keep_last_q : KEEP_ALL;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_q     <= ST_IDLE;
            len_q       <= PAYLOAD_MIN;
            last_beat_q <= '0;
            keep_last_q <= KEEP_ALL;
            beat_q      <= '0;
            seq_q       <= SEQ_RESET;
            tuser_q     <= 1'b0;
        end else begin
            state_q     <= state_d;
            len_q       <= len_d;
            last_beat_q <= last_beat_d;
            keep_last_q <= keep_last_d;
            beat_q      <= beat_d;
            seq_q       <= seq_d;
            tuser_q     <= 1'b0;
        end
    end

    // beats wait here; the output register holds a beat until taken
    etg_fifo #(
        .WIDTH (FIFO_W),
        .DEPTH (DEPTH)
    ) u_fifo (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .in_valid  (push),
        .in_ready  (fifo_in_ready),
        .in_data   ({is_last, beat_keep, beat_data}),
        .out_valid (tx_axis_tvalid),
        .out_ready (tx_axis_tready),
        .out_data  (fifo_out)
    );

    assign tx_axis_tdata = fifo_out[DATA_W-1:0];
    assign tx_axis_tkeep = fifo_out[DATA_W +: KEEP_W];
    assign tx_axis_tlast = fifo_out[FIFO_W-1];
    assign tx_axis_tuser = tuser_q;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    sequence s_stall;
        tx_axis_tvalid && !tx_axis_tready;
    endsequence

    sequence s_last_push;
        push && is_last;
    endsequence

    chk_beat_held : assert property (s_stall |=> tx_axis_tvalid && $stable(tx_axis_tdata)
        && $stable(tx_axis_tkeep) && $stable(tx_axis_tlast))
        else $error("offered beat changed before acceptance");

    chk_keep_full : assert property (tx_axis_tvalid && !tx_axis_tlast |->
        tx_axis_tkeep == KEEP_ALL)
        else $error("keep not all ones on inner beat");

    chk_keep_packed : assert property (tx_axis_tvalid && tx_axis_tlast |->
        tx_axis_tkeep != '0 && ((KEEP_W'(tx_axis_tkeep + KEEP_ONE) & tx_axis_tkeep) == '0))
        else $error("final keep not packed from lane 0");

    chk_user_low : assert property (!tx_axis_tuser)
        else $error("underrun sideband asserted");

    chk_reset_idle : assert property (disable iff (1'b0) rst |=>
        !tx_axis_tvalid && seq_q == SEQ_RESET && state_q == ST_IDLE)
        else $error("reset did not idle the generator");

    chk_seq_step : assert property (s_last_push |=> seq_q == SEQ_W'($past(seq_q) + SEQ_STEP))
        else $error("sequence counter not stepped by one");

    chk_len_range : assert property (state_q == ST_SEND |->
        len_q >= PAYLOAD_MIN && len_q <= PAYLOAD_MAX)
        else $error("payload size outside 46..1500");

    chk_first_beat : assert property (push && beat_q == BEAT_HDR0 |->
        beat_data[7:0] == peer_dest_addr_param[47:40]
        && beat_data[63:56] == local_source_addr_param[39:32])
        else $error("first beat lane layout wrong");

    chk_len_field : assert property (push && beat_q == BEAT_HDR1 |->
        {beat_data[39:32], beat_data[47:40]} == len_q)
        else $error("length field differs from payload size");

    chk_frame_bytes : assert property (s_last_push |->
        LEN_W'({beat_q, 3'h0} + $countones(beat_keep)) == LEN_W'(len_q + HDR_BYTES))
        else $error("frame byte count not header plus payload");

    chk_idle_hold : assert property (state_q == ST_IDLE && !enable_gen |=>
        state_q == ST_IDLE)
        else $error("frame started while disabled");

    sequence s_start;
        state_q == ST_IDLE && enable_gen;
    endsequence

    chk_start_latch : assert property (s_start |=>
        state_q == ST_SEND && beat_q == BEAT_HDR0 && len_q == $past(pay_sel))
        else $error("frame start did not latch the payload size");

    chk_first_valid : assert property (s_start ##1 push |-> ##[1:2] tx_axis_tvalid)
        else $error("first beat of a frame never offered");

    chk_idle_no_push : assert property (state_q == ST_IDLE |-> !push)
        else $error("beat pushed while builder idle");

    chk_beat_step : assert property (push && !is_last |=>
        beat_q == BEAT_W'($past(beat_q) + BEAT_STEP) && state_q == ST_SEND)
        else $error("beat index not stepped by one");

    chk_seq_hold : assert property (!(push && is_last) |=> $stable(seq_q))
        else $error("sequence counter moved outside a frame end");

    chk_len_hold : assert property (state_q == ST_SEND |=> $stable(len_q))
        else $error("payload size changed inside a frame");

    chk_src_tail : assert property (push && beat_q == BEAT_HDR1 |->
        beat_data[7:0] == local_source_addr_param[31:24]
        && beat_data[63:48] == {seq_q[7:0], seq_q[15:8]})
        else $error("second beat lane layout wrong");

    chk_seq_lanes : assert property (push && beat_q > BEAT_HDR1 |->
        beat_data[15:0] == {seq_q[7:0], seq_q[15:8]})
        else $error("payload lanes do not carry the sequence number");

endmodule : etg_frame_gen
`default_nettype wire

// [shared/etg_pkg.sv]
// constants and types shared by the test frame generator files
package etg_pkg;

    localparam int DATA_W      = 64;
    localparam int KEEP_W      = 8;
    localparam int LEN_W       = 16;
    localparam int SEQ_W       = 16;
    localparam int BEAT_W      = 8;
    localparam int ADDR_W      = 48;
    localparam int FIFO_DEPTH  = 8;
    localparam int FIFO_W      = DATA_W + KEEP_W + 1;

    // payload limits and header size, in bytes
    localparam logic [LEN_W-1:0] PAYLOAD_MIN = 16'h002e;
    localparam logic [LEN_W-1:0] PAYLOAD_MAX = 16'h05dc;
    localparam logic [LEN_W-1:0] HDR_BYTES   = 16'h000e;
    localparam logic [LEN_W-1:0] BEAT_ROUND  = 16'h0007;

    // channel address defaults
    localparam logic [ADDR_W-1:0] ADDR_CH0 = 48'h111_1000_0000;
    localparam logic [ADDR_W-1:0] ADDR_CH1 = 48'h222_2000_0000;

    localparam logic [KEEP_W-1:0] KEEP_ALL  = 8'hff;
    localparam logic [KEEP_W-1:0] KEEP_ONE  = 8'h01;
    localparam logic [BEAT_W-1:0] BEAT_HDR0 = 8'h00;
    localparam logic [BEAT_W-1:0] BEAT_HDR1 = 8'h01;
    localparam logic [BEAT_W-1:0] BEAT_STEP = 8'h01;
    localparam logic [SEQ_W-1:0]  SEQ_RESET = 16'h0000;
    localparam logic [SEQ_W-1:0]  SEQ_STEP  = 16'h0001;

    typedef enum logic {
        ST_IDLE,
        ST_SEND
    } etg_state_t;

endpackage : etg_pkg

// [tb/etg_mac_model.sv]
// stand-in for the mac transmit port: offers ready promptly or with random stalls
`timescale 1ns/1ns
`default_nettype none
module etg_mac_model (
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic [1:0] stall_mode,
    output logic            tx_axis_tready
);
    int seed = 32'h126a9630;
    int r;
    // mode 0 always takes, mode 1 about half the cycles, others one cycle in four
    always @(posedge ref_clk) begin
        r = $random(seed);
        if (rst)
            tx_axis_tready <= 1'b0;
        else if (stall_mode == 2'h0)
            tx_axis_tready <= 1'b1;
        else if (stall_mode == 2'h1)
            tx_axis_tready <= r[0];
        else
            tx_axis_tready <= (r[1:0] == 2'h0);
    end
endmodule : etg_mac_model
`default_nettype wire

// [tb/tb_ethernet_test_frame_generator.sv]
// self-checking bench for the test frame generator
`timescale 1ns/1ns
`default_nettype none
module tb_ethernet_test_frame_generator;
    import etg_pkg::*;
    localparam int CYCLE_LIMIT = 40000;
    logic              ref_clk = 1'b0;
    logic              rst = 1'b1;
    logic              enable_gen = 1'b0;
    logic [LEN_W-1:0]  data_payload = PAYLOAD_MIN;
    logic [1:0]        stall_mode = 2'h0;
    logic              tx_axis_tready;
    logic [DATA_W-1:0] tx_axis_tdata;
    logic [KEEP_W-1:0] tx_axis_tkeep;
    logic              tx_axis_tlast;
    logic              tx_axis_tvalid;
    logic              tx_axis_tuser;
    int                n_errors = 0;
    int                comparisons = 0;
    int                seed = 32'h126a9630;
    int                cycles = 0;
    int                beat = 0;
    int                frames = 0;
    logic [LEN_W-1:0]  cur_len = PAYLOAD_MIN;
    logic [SEQ_W-1:0]  exp_seq = SEQ_RESET;
    logic [73:0]       held;
    logic              was_stalled = 1'b0;
    logic [LEN_W-1:0]  corner [8] = '{16'h002e, 16'h002f, 16'h0032, 16'h0034,
                                      16'h0035, 16'h05dc, 16'h000a, 16'h07d0};

    always #50 ref_clk = ~ref_clk;

    etg_frame_gen dut (
        .ref_clk        (ref_clk),
        .rst            (rst),
        .enable_gen     (enable_gen),
        .data_payload   (data_payload),
        .tx_axis_tready (tx_axis_tready),
        .tx_axis_tdata  (tx_axis_tdata),
        .tx_axis_tkeep  (tx_axis_tkeep),
        .tx_axis_tlast  (tx_axis_tlast),
        .tx_axis_tvalid (tx_axis_tvalid),
        .tx_axis_tuser  (tx_axis_tuser)
    );

    etg_mac_model mac (
        .ref_clk        (ref_clk),
        .rst            (rst),
        .stall_mode     (stall_mode),
        .tx_axis_tready (tx_axis_tready)
    );

    task automatic results;
        if (n_errors == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : results

    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    function automatic logic [LEN_W-1:0] clamp(input logic [LEN_W-1:0] p);
        if (p < PAYLOAD_MIN)
            return PAYLOAD_MIN;
        if (p > PAYLOAD_MAX)
            return PAYLOAD_MAX;
        return p;
    endfunction : clamp

    // byte i of a frame: dest, src, length, then the sequence number repeated
    function automatic logic [7:0] fbyte(input int i, input logic [LEN_W-1:0] len,
                                         input logic [SEQ_W-1:0] sq);
        logic [95:0] hdr;
        hdr = {ADDR_CH1, ADDR_CH0};
        if (i < 12)
            return hdr[95-8*i -: 8];
        if (i < 14)
            return len[15-8*(i-12) -: 8];
        return i[0] ? sq[7:0] : sq[15:8];
    endfunction : fbyte

    always @(posedge ref_clk) begin : monitor
        logic [DATA_W-1:0] ed;
        logic [DATA_W-1:0] mask;
        logic [KEEP_W-1:0] ek;
        int                rem;
        cycles++;
        if (rst) begin
            beat = 0;
            exp_seq = SEQ_RESET;
            was_stalled = 1'b0;
        end else begin
            if (was_stalled)
                check({tx_axis_tvalid, tx_axis_tlast, tx_axis_tkeep, tx_axis_tdata}, held);
            was_stalled = tx_axis_tvalid && !tx_axis_tready;
            held = {tx_axis_tvalid, tx_axis_tlast, tx_axis_tkeep, tx_axis_tdata};
            if (tx_axis_tvalid && tx_axis_tready) begin
                rem = 14 + cur_len - 8 * beat;
                ek = (rem >= 8) ? KEEP_ALL : KEEP_W'((1 << rem) - 1);
                for (int k = 0; k < 8; k++) begin
                    ed[8*k +: 8] = ek[k] ? fbyte(8 * beat + k, cur_len, exp_seq) : 8'h00;
                    mask[8*k +: 8] = {8{ek[k]}};
                end
                check(tx_axis_tdata & mask, ed);
                check(tx_axis_tkeep, ek);
                check(tx_axis_tlast, rem <= 8);
                check(tx_axis_tuser, 1'b0);
                beat++;
                if (rem <= 8) begin
                    beat = 0;
                    frames++;
                    exp_seq++;
                end
            end
        end
        if (cycles >= CYCLE_LIMIT) begin
            n_errors++;
            results();
        end
    end

    // enable for n frames, then drop enable and wait for the stream to go quiet
    task automatic run_frames(input logic [LEN_W-1:0] p, input int n);
        int target;
        int quiet;
        data_payload <= p;
        stall_mode <= 2'($random(seed));
        @(posedge ref_clk);
        cur_len = clamp(p);
        target = frames + n;
        enable_gen <= 1'b1;
        while (frames < target)
            @(posedge ref_clk);
        enable_gen <= 1'b0;
        quiet = 0;
        while (quiet < 40) begin
            @(posedge ref_clk);
            quiet = tx_axis_tvalid ? 0 : quiet + 1;
        end
        check(beat, 0);
    endtask : run_frames

    initial begin : main
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        check({tx_axis_tvalid, tx_axis_tuser}, 2'b00);
        foreach (corner[i])
            run_frames(corner[i], 3);
        repeat (6)
            run_frames(16'(PAYLOAD_MIN + $unsigned($random(seed)) % 1455), 2);
        // reset in the middle of traffic must restart the sequence count
        enable_gen <= 1'b1;
        repeat (30) @(posedge ref_clk);
        rst <= 1'b1;
        enable_gen <= 1'b0;
        repeat (2) @(posedge ref_clk);
        check(tx_axis_tvalid, 1'b0);
        rst <= 1'b0;
        run_frames(16'h0040, 2);
        results();
    end
endmodule : tb_ethernet_test_frame_generator
`default_nettype wire
